// [rtl/uasc_status_control.sv]
// Purpose: status/control, queues and line engines of a serial transceiver
// Assumes: classic Wishbone slave, one clock, synchronous active-high reset
// Notes: all state sits in one struct, next value built in one process
// Operation
// - select 00: request on every character load, none on a break load
// - select 10: request when load empties queue
// - select 01: request when all shifted out, none while send_break is set
// - raw line: invert makes idle low
// - infrared: invert makes encoded idle high
// - break sends start, twelve zeros, stop
// - disable aborts, flushes, releases pin
// - buffer full flag when queue full
// - empty flag when shifter and queue empty
// - select 11: request on fourth character
// - select 10: request on third character
// - select 0x: request on every character
// - address detect only in 9-bit mode
// - idle flag high while receiver idle
// - parity flag of head character
// - framing flag of head character
// - overrun set by hardware, cleared by software
// - overrun clear flushes receive path
// - data available while queue not empty
// - bit 12 reads zero
// - mode bit selects infrared codec
// - format 11 is 9-bit, no parity
// - receive queue four deep
// - transmit queue four deep
//
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none

module uasc_status_control (
   input wire logic clk_i, // 25 MHz clock
   input wire logic rst_i, // synchronous reset
   input wire uasc_pkg::uasc_wb_req_t wb_i, // bus request
   output uasc_pkg::uasc_wb_rsp_t wb_o, // bus answer
   input wire logic serial_rx_i, // serial_rx_pin
   output logic serial_tx_o, // serial_tx_pin level
   output logic serial_tx_oe_o, // serial_tx_pin driven
   output logic tx_irq_o, // transmit request pulse
   output logic rx_irq_o // receive request pulse
);
   import uasc_pkg::*;

   // ----------------------------------------
   // helpers
   // ----------------------------------------

   // frame length in bits, start and stops included
   function automatic logic [3:0] len_f(input logic [1:0] pd, input logic st);
      logic [3:0] n;
      n = 4'hA;
      if (pd != 2'h0) begin // 9 bit or parity adds one
         n = 4'hB;
      end
      if (st) begin // second stop bit
         n = n + 4'h1;
      end
      return n;
   endfunction

   // serial frame, lsb first, idle ones above the stop bits
   function automatic logic [13:0] frame_f(input logic [8:0] d, input logic [1:0] pd);
      logic [13:0] f;
      f = '1;
      f[0] = 1'b0; // start bit
      f[8:1] = d[7:0];
      if (pd == UASC_PD_9BIT) begin // ninth data bit
         f[9] = d[8];
      end else if (pd == UASC_PD_EVEN) begin
         f[9] = ^d[7:0];
      end else if (pd == UASC_PD_ODD) begin
         f[9] = ~^d[7:0];
      end
      return f;
   endfunction

   // ----------------------------------------
   // state and temporaries
   // ----------------------------------------
   uasc_state_t s_q; // registered state
   uasc_state_t s_d; // next state
   logic acc; // bus access completes this edge
   logic wr; // completing write
   logic rd; // completing read
   logic tpush; // tx queue push
   logic tpop; // tx queue pop
   logic tload; // shifter loaded with a character
   logic tdone; // frame fully shifted out
   logic rpush; // rx queue push
   logic rpop; // rx queue pop
   logic rovf; // character lost to a full queue
   logic rflush; // receive path reset
   logic rdone; // frame received
   logic skip; // character filtered by address detect
   logic tl; // unencoded transmit level
   logic enc; // infrared pulse
   logic [15:0] quarter; // infrared pulse end point
   logic [10:0] head; // receive queue head
   logic [15:0] sta; // status and control read view
   logic [3:0] rlast; // position of the final stop bit

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.tx_irq = 1'b0;
      s_d.rx_irq = 1'b0;
      tpop = 1'b0;
      tload = 1'b0;
      tdone = 1'b0;
      rpush = 1'b0;
      rovf = 1'b0;
      rflush = 1'b0;
      rdone = 1'b0;
      skip = 1'b0;
      rlast = len_f(s_q.pdsel, s_q.stsel) - 4'h2;

      // bus phase: answer one cycle after the request, act at the ack edge
      acc = wb_i.cyc & wb_i.stb & s_q.ack;
      wr = acc & wb_i.we;
      rd = acc & ~wb_i.we;
      s_d.ack = wb_i.cyc & wb_i.stb & ~s_q.ack;
      tpush = wr && wb_i.adr == UASC_TXD_OFS && wb_i.sel[0] && s_q.tx_en && s_q.txn != UASC_FULL_CNT;
      rpop = rd && wb_i.adr == UASC_RXD_OFS && s_q.rxn != 3'h0;

      // status view of the head character
      head = (s_q.rxn != 3'h0) ? s_q.rxf[s_q.rxr] : 11'h000;
      sta = 16'h0000; // unused bits, bit 12 among them, read zero
      sta[UASC_TXSEL_HI_BIT] = s_q.tx_sel[1];
      sta[UASC_TXINV_BIT] = s_q.tx_inv;
      sta[UASC_TXSEL_LO_BIT] = s_q.tx_sel[0];
      sta[UASC_BRK_BIT] = s_q.brk;
      sta[UASC_TXEN_BIT] = s_q.tx_en;
      sta[UASC_TXBF_BIT] = s_q.txn == UASC_FULL_CNT;
      sta[UASC_TXMT_BIT] = s_q.tst == UASC_TX_IDLE && s_q.txn == 3'h0;
      sta[UASC_RXSEL_BIT+:2] = s_q.rx_sel;
      sta[UASC_ADDRESS_DETECT_ENABLE_BIT] = s_q.address_detect_enable;
      sta[UASC_RX_IDLE_FLAG_BIT] = s_q.rst == UASC_RX_IDLE;
      sta[UASC_PARITY_ERROR_FLAG_BIT] = head[9];
      sta[UASC_FRAMING_ERROR_FLAG_BIT] = head[10];
      sta[UASC_OVERRUN_FLAG_BIT] = s_q.overrun_flag;
      sta[UASC_RXDA_BIT] = s_q.rxn != 3'h0;

      // read data, latched as ack rises; unmapped reads give zero
      s_d.rdat = 32'h00000000;
      if (wb_i.adr == UASC_STA_OFS) begin
         s_d.rdat[15:0] = sta;
      end else if (wb_i.adr == UASC_MODE_OFS) begin
         s_d.rdat[UASC_INFRARED_CODEC_ENABLE_BIT] = s_q.infrared_codec_enable;
         s_d.rdat[UASC_PDSEL_BIT+:2] = s_q.pdsel;
         s_d.rdat[UASC_STSEL_BIT] = s_q.stsel;
      end else if (wb_i.adr == UASC_RXD_OFS) begin
         s_d.rdat[8:0] = head[8:0];
      end else if (wb_i.adr == UASC_BRG_OFS) begin
         s_d.rdat[15:0] = s_q.brg;
      end

      // ----------------------------------------
      // transmitter
      // ----------------------------------------
      case (s_q.tst)
         UASC_TX_IDLE: begin
            if (s_q.tx_en && s_q.brk) begin // break before any queued data
               s_d.tsh = UASC_BRK_FRAME;
               s_d.tbits = UASC_BRK_LEN;
               s_d.tcnt = s_q.brg;
               s_d.tbrk = 1'b1;
               s_d.tst = UASC_TX_SHIFT;
            end else if (s_q.tx_en && s_q.txn != 3'h0) begin // load from queue
               s_d.tsh = frame_f(s_q.txf[s_q.txr], s_q.pdsel);
               s_d.tbits = len_f(s_q.pdsel, s_q.stsel);
               s_d.tcnt = s_q.brg;
               s_d.tbrk = 1'b0;
               s_d.txr = s_q.txr + 2'h1;
               tpop = 1'b1;
               tload = 1'b1;
               s_d.tst = UASC_TX_SHIFT;
            end
         end
         UASC_TX_SHIFT: begin
            if (s_q.tcnt != 16'h0000) begin // within a bit
               s_d.tcnt = s_q.tcnt - 16'h0001;
            end else if (s_q.tbits == 4'h1) begin // last bit ends
               s_d.tst = UASC_TX_IDLE;
               tdone = 1'b1;
               if (s_q.tbrk) begin // hardware ends the break
                  s_d.brk = 1'b0;
               end
            end else begin // next bit
               s_d.tcnt = s_q.brg;
               s_d.tsh = {1'b1, s_q.tsh[13:1]};
               s_d.tbits = s_q.tbits - 4'h1;
            end
         end
         default: begin
            s_d.tst = UASC_TX_IDLE;
         end
      endcase

      // pin level: raw or infrared encoded, then polarity
      tl = (s_q.tst == UASC_TX_SHIFT) ? s_q.tsh[0] : UASC_LINE_IDLE;
      quarter = s_q.brg - (s_q.brg >> 2);
      enc = (s_q.tst == UASC_TX_SHIFT) && !tl && s_q.tcnt >= quarter;
      if (s_q.infrared_codec_enable) begin
         s_d.txout = enc ^ s_q.tx_inv;
      end else begin
         s_d.txout = tl ^ s_q.tx_inv;
      end
      s_d.txoe = s_q.tx_en;

      // ----------------------------------------
      // receiver
      // ----------------------------------------
      s_d.rsync1 = serial_rx_i;
      s_d.rsync2 = s_q.rsync1;
      s_d.rprev = s_q.rsync2;
      case (s_q.rst)
         UASC_RX_IDLE: begin
            if (s_q.rprev && !s_q.rsync2) begin // falling edge, start bit
               s_d.rst = UASC_RX_START;
               s_d.rcnt = s_q.brg >> 1;
            end
         end
         UASC_RX_START: begin
            if (s_q.rcnt != 16'h0000) begin // wait to mid bit
               s_d.rcnt = s_q.rcnt - 16'h0001;
            end else if (s_q.rsync2) begin // glitch, not a start
               s_d.rst = UASC_RX_IDLE;
            end else begin
               s_d.rst = UASC_RX_DATA;
               s_d.rcnt = s_q.brg;
               s_d.rpos = 4'h0;
            end
         end
         UASC_RX_DATA: begin
            if (s_q.rcnt != 16'h0000) begin // wait to mid bit
               s_d.rcnt = s_q.rcnt - 16'h0001;
            end else if (s_q.rpos == rlast) begin // final stop bit
               s_d.rst = UASC_RX_IDLE;
               rdone = 1'b1;
            end else begin // store a bit
               s_d.rsh[s_q.rpos] = s_q.rsync2;
               s_d.rpos = s_q.rpos + 4'h1;
               s_d.rcnt = s_q.brg;
            end
         end
         default: begin
            s_d.rst = UASC_RX_IDLE;
         end
      endcase

      // completed character: filter, then queue or overrun
      if (rdone) begin
         skip = s_q.address_detect_enable && s_q.pdsel == UASC_PD_9BIT && !s_q.rsh[8];
         if (!skip && s_q.rxn == UASC_FULL_CNT && !rpop) begin
            rovf = 1'b1;
            s_d.overrun_flag = 1'b1;
         end else if (!skip) begin
            rpush = 1'b1;
            s_d.rxf[s_q.rxw][10] = !s_q.rsync2;
            if (s_q.pdsel == UASC_PD_EVEN) begin
               s_d.rxf[s_q.rxw][9] = ^s_q.rsh[8:0];
            end else if (s_q.pdsel == UASC_PD_ODD) begin
               s_d.rxf[s_q.rxw][9] = ~^s_q.rsh[8:0];
            end else begin
               s_d.rxf[s_q.rxw][9] = 1'b0;
            end
            s_d.rxf[s_q.rxw][8] = s_q.pdsel == UASC_PD_9BIT && s_q.rsh[8];
            s_d.rxf[s_q.rxw][7:0] = s_q.rsh[7:0];
            s_d.rxw = s_q.rxw + 2'h1;
         end
      end

      // ----------------------------------------
      // register writes
      // ----------------------------------------
      if (wr && wb_i.adr == UASC_STA_OFS) begin
         if (wb_i.sel[1]) begin // control, high byte
            s_d.tx_sel = {wb_i.dat[UASC_TXSEL_HI_BIT], wb_i.dat[UASC_TXSEL_LO_BIT]};
            s_d.tx_inv = wb_i.dat[UASC_TXINV_BIT];
            s_d.brk = wb_i.dat[UASC_BRK_BIT] | s_d.brk;
            s_d.tx_en = wb_i.dat[UASC_TXEN_BIT];
         end
         if (wb_i.sel[0]) begin // control, low byte
            s_d.rx_sel = wb_i.dat[UASC_RXSEL_BIT+:2];
            s_d.address_detect_enable = wb_i.dat[UASC_ADDRESS_DETECT_ENABLE_BIT];
            if (!wb_i.dat[UASC_OVERRUN_FLAG_BIT] && s_q.overrun_flag && !rovf) begin // new overrun wins
               s_d.overrun_flag = 1'b0;
               rflush = 1'b1;
            end
         end
      end else if (wr && wb_i.adr == UASC_MODE_OFS) begin
         if (wb_i.sel[1]) begin
            s_d.infrared_codec_enable = wb_i.dat[UASC_INFRARED_CODEC_ENABLE_BIT];
         end
         if (wb_i.sel[0]) begin
            s_d.pdsel = wb_i.dat[UASC_PDSEL_BIT+:2];
            s_d.stsel = wb_i.dat[UASC_STSEL_BIT];
         end
      end else if (wr && wb_i.adr == UASC_BRG_OFS) begin
         if (wb_i.sel[0]) begin
            s_d.brg[7:0] = wb_i.dat[7:0];
         end
         if (wb_i.sel[1]) begin
            s_d.brg[15:8] = wb_i.dat[15:8];
         end
      end
      if (tpush) begin // queue a character
         s_d.txf[s_q.txw] = {wb_i.sel[1] & wb_i.dat[8], wb_i.dat[7:0]};
         s_d.txw = s_q.txw + 2'h1;
      end
      if (rpop) begin // read takes the head
         s_d.rxr = s_q.rxr + 2'h1;
      end

      // ----------------------------------------
      // fill counts and request pulses
      // ----------------------------------------
      s_d.txn = s_q.txn + {2'h0, tpush} - {2'h0, tpop};
      s_d.rxn = s_q.rxn + {2'h0, rpush} - {2'h0, rpop};
      if (tload && s_q.tx_sel == UASC_TXI_EACH) begin
         s_d.tx_irq = 1'b1;
      end else if (tload && s_q.tx_sel == UASC_TXI_EMPTY && s_d.txn == 3'h0) begin
         s_d.tx_irq = 1'b1;
      end else if (tdone && s_q.tx_sel == UASC_TXI_DONE && s_d.txn == 3'h0 && !s_q.brk) begin
         s_d.tx_irq = 1'b1;
      end
      if (rpush && !s_q.rx_sel[1]) begin
         s_d.rx_irq = 1'b1;
      end else if (rpush && s_q.rx_sel == UASC_RXI_3 && s_d.rxn == UASC_RX_THREE) begin
         s_d.rx_irq = 1'b1;
      end else if (rpush && s_q.rx_sel == UASC_RXI_4 && s_d.rxn == UASC_FULL_CNT) begin
         s_d.rx_irq = 1'b1;
      end

      // transmit disabled: abort and empty the queue
      if (!s_q.tx_en) begin
         s_d.tst = UASC_TX_IDLE;
         s_d.txn = 3'h0;
         s_d.txr = 2'h0;
         s_d.txw = 2'h0;
         s_d.tx_irq = 1'b0;
      end

      // overrun cleared: receive queue and shifter back to empty
      if (rflush) begin
         s_d.rxn = 3'h0;
         s_d.rxr = 2'h0;
         s_d.rxw = 2'h0;
         s_d.rst = UASC_RX_IDLE;
         s_d.rpos = 4'h0;
         s_d.rsh = 12'h000;
         s_d.rx_irq = 1'b0;
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.brg <= UASC_BRG_RST;
         s_q.rsync1 <= UASC_LINE_IDLE;
         s_q.rsync2 <= UASC_LINE_IDLE;
         s_q.rprev <= UASC_LINE_IDLE;
         s_q.txout <= UASC_LINE_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // outputs, all from flip-flops
   // ----------------------------------------
   assign wb_o.ack = s_q.ack;
   assign wb_o.dat = s_q.rdat;
   assign serial_tx_o = s_q.txout;
   assign serial_tx_oe_o = s_q.txoe;
   assign tx_irq_o = s_q.tx_irq;
   assign rx_irq_o = s_q.rx_irq;

endmodule

`default_nettype wire

// [rtl/uasc_pkg.sv]
// Purpose: shared constants and types of the serial status/control block
// Assumes: 32-bit classic Wishbone, byte addresses, one word per register
// Notes: widths follow the 4-deep transmit and receive queues
package uasc_pkg;

   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] UASC_STA_OFS = 8'h00; // status and control
   localparam logic [7:0] UASC_MODE_OFS = 8'h04; // line format and codec
   localparam logic [7:0] UASC_TXD_OFS = 8'h08; // transmit data, write pushes
   localparam logic [7:0] UASC_RXD_OFS = 8'h0C; // receive data, read pops
   localparam logic [7:0] UASC_BRG_OFS = 8'h10; // bit period minus one

   // ----------------------------------------
   // status and control field positions
   // ----------------------------------------
   localparam int UASC_TXSEL_HI_BIT = 15; // tx_irq_select_hi
   localparam int UASC_TXINV_BIT = 14; // tx_polarity_invert
   localparam int UASC_TXSEL_LO_BIT = 13; // tx_irq_select_lo
   localparam int UASC_BRK_BIT = 11; // send_break
   localparam int UASC_TXEN_BIT = 10; // tx_enable
   localparam int UASC_TXBF_BIT = 9; // tx_buffer_full
   localparam int UASC_TXMT_BIT = 8; // tx_all_empty
   localparam int UASC_RXSEL_BIT = 6; // rx_irq_select, two bits
   localparam int UASC_ADDRESS_DETECT_ENABLE_BIT = 5; // address_detect_enable
   localparam int UASC_RX_IDLE_FLAG_BIT = 4; // rx_idle_flag
   localparam int UASC_PARITY_ERROR_FLAG_BIT = 3; // parity_error_flag
   localparam int UASC_FRAMING_ERROR_FLAG_BIT = 2; // framing_error_flag
   localparam int UASC_OVERRUN_FLAG_BIT = 1; // overrun_flag
   localparam int UASC_RXDA_BIT = 0; // rx_data_available

   // ----------------------------------------
   // mode field positions
   // ----------------------------------------
   localparam int UASC_INFRARED_CODEC_ENABLE_BIT = 12; // infrared_codec_enable
   localparam int UASC_PDSEL_BIT = 1; // parity_data_select, two bits
   localparam int UASC_STSEL_BIT = 0; // two stop bits

   // ----------------------------------------
   // reset values and sizes
   // ----------------------------------------
   localparam int UASC_DEPTH = 4; // entries per queue
   localparam logic [2:0] UASC_FULL_CNT = 3'h4; // count of a full queue
   localparam logic [15:0] UASC_BRG_RST = 16'h000F; // bit period minus one at reset
   localparam logic UASC_LINE_IDLE = 1'b1; // idle level of the raw line

   // ----------------------------------------
   // mode encodings
   // ----------------------------------------
   localparam logic [1:0] UASC_PD_EVEN = 2'h1; // 8 bit, even parity
   localparam logic [1:0] UASC_PD_ODD = 2'h2; // 8 bit, odd parity
   localparam logic [1:0] UASC_PD_9BIT = 2'h3; // 9 bit, no parity
   localparam logic [1:0] UASC_TXI_EACH = 2'h0; // every character load
   localparam logic [1:0] UASC_TXI_DONE = 2'h1; // all shifted out
   localparam logic [1:0] UASC_TXI_EMPTY = 2'h2; // load empties queue
   localparam logic [1:0] UASC_RXI_3 = 2'h2; // queue reaches three
   localparam logic [1:0] UASC_RXI_4 = 2'h3; // queue reaches four
   localparam logic [2:0] UASC_RX_THREE = 3'h3; // threshold count
   localparam logic [13:0] UASC_BRK_FRAME = 14'h2000; // start, 12 zeros, stop
   localparam logic [3:0] UASC_BRK_LEN = 4'hE; // bits in a break frame

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [0:0] {UASC_TX_IDLE, UASC_TX_SHIFT} uasc_tx_st_t;
   typedef enum logic [1:0] {UASC_RX_IDLE, UASC_RX_START, UASC_RX_DATA} uasc_rx_st_t;

   typedef struct packed {
      logic cyc; // bus cycle
      logic stb; // strobe
      logic we; // write
      logic [7:0] adr; // byte address
      logic [3:0] sel; // byte lanes
      logic [31:0] dat; // write data
   } uasc_wb_req_t;

   typedef struct packed {
      logic ack; // acknowledge
      logic [31:0] dat; // read data
   } uasc_wb_rsp_t;

   typedef struct packed {
      logic ack; // bus acknowledge
      logic [31:0] rdat; // bus read data
      logic [1:0] tx_sel; // tx_irq_select
      logic tx_inv; // tx_polarity_invert
      logic brk; // send_break
      logic tx_en; // tx_enable
      logic [1:0] rx_sel; // rx_irq_select
      logic address_detect_enable; // address_detect_enable
      logic overrun_flag; // overrun_flag
      logic infrared_codec_enable; // infrared_codec_enable
      logic [1:0] pdsel; // parity_data_select
      logic stsel; // two stop bits
      logic [15:0] brg; // bit period minus one
      logic [UASC_DEPTH-1:0][8:0] txf; // transmit queue
      logic [1:0] txw; // tx write index
      logic [1:0] txr; // tx read index
      logic [2:0] txn; // tx fill count
      logic [UASC_DEPTH-1:0][10:0] rxf; // receive queue, errors on top
      logic [1:0] rxw; // rx write index
      logic [1:0] rxr; // rx read index
      logic [2:0] rxn; // rx fill count
      uasc_tx_st_t tst; // transmitter state
      logic [13:0] tsh; // transmit shifter
      logic [3:0] tbits; // bits left in frame
      logic [15:0] tcnt; // tx bit timer
      logic tbrk; // frame is a break
      uasc_rx_st_t rst; // receiver state
      logic rsync1; // line synchroniser, first stage
      logic rsync2; // line synchroniser, second stage
      logic rprev; // previous synchronised level
      logic [11:0] rsh; // receive shifter
      logic [3:0] rpos; // next bit position
      logic [15:0] rcnt; // rx bit timer
      logic tx_irq; // transmit request pulse
      logic rx_irq; // receive request pulse
      logic txout; // transmit pin level
      logic txoe; // transmit pin owned
   } uasc_state_t;

endpackage

// [verif/uasc_chk_asserts.sv]
// Purpose: bus, pin and request checks of the status/control block
// Assumes: sees only the top ports
// Notes: bound to every instance of the block
`timescale 1ns/1ns
`default_nettype none
module uasc_chk (
   input wire logic clk_i, // clock
   input wire logic rst_i, // reset
   input wire uasc_pkg::uasc_wb_req_t wb_i, // request
   input wire uasc_pkg::uasc_wb_rsp_t wb_o, // answer
   input wire logic serial_rx_i, // rx line
   input wire logic serial_tx_o, // tx level
   input wire logic serial_tx_oe_o, // tx owned
   input wire logic tx_irq_o, // tx pulse
   input wire logic rx_irq_o // rx pulse
);
   import uasc_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ------------------------------
   // status register accesses
   // ------------------------------
   sequence sta_wr;
      wb_o.ack && wb_i.we && wb_i.sel[1] && wb_i.adr == UASC_STA_OFS;
   endsequence
   sequence sta_rd;
      wb_o.ack && !wb_i.we && wb_i.adr == UASC_STA_OFS;
   endsequence
   AST_ACK_LAT: assert property (wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack)
      else $error("ack not one cycle after request");
   AST_ACK_ONE: assert property (wb_o.ack |=> !wb_o.ack)
      else $error("ack held too long");
   AST_ACK_CAUSE: assert property ($rose(wb_o.ack) |-> $past(wb_i.cyc && wb_i.stb))
      else $error("ack without request");
   AST_TX_PULSE: assert property (tx_irq_o |=> !tx_irq_o)
      else $error("tx request wider than one cycle");
   AST_RX_PULSE: assert property (rx_irq_o |=> !rx_irq_o)
      else $error("rx request wider than one cycle");
   AST_RST_IDLE: assert property ($fell(rst_i) |-> serial_tx_o && !serial_tx_oe_o)
      else $error("tx pin not idle after reset");
   AST_BIT12: assert property (sta_rd |-> wb_o.dat[12] == 1'b0 && wb_o.dat[31:16] == 16'h0000)
      else $error("unused status bits not zero");
   AST_OE: assert property (sta_wr |-> ##2 serial_tx_oe_o == $past(wb_i.dat[UASC_TXEN_BIT], 2))
      else $error("pin ownership does not follow enable");
   AST_EMPTY_FULL: assert property (sta_rd and wb_o.dat[UASC_TXMT_BIT] |-> !wb_o.dat[UASC_TXBF_BIT])
      else $error("empty and full together");
endmodule
bind uasc_status_control uasc_chk u_chk (.clk_i, .rst_i, .wb_i, .wb_o, .serial_rx_i, .serial_tx_o,
   .serial_tx_oe_o, .tx_irq_o, .rx_irq_o);
`default_nettype wire

// [verif/uasc_peer.sv]
// Purpose: remote serial peer sending frames on the receive line
// Assumes: bit time fixed by BIT clocks
// Notes: line idles high between frames
`timescale 1ns/1ns
`default_nettype none
module uasc_peer #(parameter int BIT = 4) (
   input wire logic clk_i, // clock
   output var logic line_o // to serial_rx_i
);
   initial line_o = 1'b1; // idle high
   // start, n bits lsb first, given stop level, one idle bit
   task automatic send(input logic [9:0] d, input int n, input logic stop);
      int i;
      line_o <= 1'b0;
      repeat (BIT) @(posedge clk_i);
      for (i = 0; i < n; i++) begin
         line_o <= d[i];
         repeat (BIT) @(posedge clk_i);
      end
      line_o <= stop;
      repeat (BIT) @(posedge clk_i);
      line_o <= 1'b1;
      repeat (BIT) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Purpose: self-checking bench of the status/control block
// Assumes: divisor 3, four clocks a bit
// Notes: reads are noted in a queue and checked at ack
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import uasc_pkg::*;
   logic clk_i = 1'b0; // clock
   logic rst_i = 1'b1; // reset
   uasc_wb_req_t req = '0; // bus request
   uasc_wb_rsp_t rsp; // bus answer
   logic rx, tx, oe, txi, rxi; // line and outputs
   int errors = 0, tests_run = 0, nt = 0, nr = 0, nl = 0, cyc = 0, n0, i, s, k;
   logic [31:0] exq[$], mkq[$], m; // expected reads, masks
   logic [9:0] b[4]; // random receive bytes
   uasc_status_control uut (.clk_i, .rst_i, .wb_i(req), .wb_o(rsp), .serial_rx_i(rx),
      .serial_tx_o(tx), .serial_tx_oe_o(oe), .tx_irq_o(txi), .rx_irq_o(rxi));
   uasc_peer #(.BIT(4)) peer (.clk_i, .line_o(rx));
   initial forever #20 clk_i = ~clk_i;
   // compare one value
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   // one classic cycle; a read notes expected value and mask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] mk = 0);
      if (!w) begin
         exq.push_back(d);
         mkq.push_back(mk);
      end
      req <= '{1'b1, 1'b1, w, a, 4'h3, w ? d : 32'h0};
      @(posedge clk_i);
      while (rsp.ack !== 1'b1)
         @(posedge clk_i);
      req <= '0;
      @(posedge clk_i);
   endtask
   task automatic print_verdict();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // watcher: read results, pulse counts and clocks with the line low, timeout
   always @(posedge clk_i) begin
      cyc++;
      nt += (txi === 1'b1);
      nr += (rxi === 1'b1);
      nl += (tx === 1'b0);
      if (rsp.ack === 1'b1 && req.we === 1'b0 && exq.size() > 0) begin
         m = mkq.pop_front();
         chk(exq.pop_front() & m, rsp.dat & m);
      end
      if (cyc > 20000) begin
         errors++;
         print_verdict();
      end
   end
   initial begin
      void'($urandom(32'h5ce9));
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(0, UASC_STA_OFS, 32'h0110, 32'hFFFFFFFF);
      bus(1, UASC_BRG_OFS, 32'h3);
      bus(1, UASC_STA_OFS, 32'h0400);
      repeat (3) @(posedge clk_i);
      chk(32'h3, {30'h0, oe, tx});
      bus(1, UASC_STA_OFS, 32'h4400);
      repeat (3) @(posedge clk_i);
      chk(32'h2, {30'h0, oe, tx});
      bus(1, UASC_MODE_OFS, 32'h1000);
      repeat (3) @(posedge clk_i);
      chk(32'h3, {30'h0, oe, tx});
      bus(1, UASC_MODE_OFS, 32'h0);
      // transmit request modes 00, 10, 01 over five characters
      for (s = 0; s < 3; s++) begin
         bus(1, UASC_STA_OFS, (s == 0) ? 32'h0400 : (s == 1) ? 32'h8400 : 32'h2400);
         n0 = nt;
         for (i = 0; i < 5; i++)
            bus(1, UASC_TXD_OFS, $urandom & 32'hFF);
         bus(0, UASC_STA_OFS, 32'h0200, 32'h0300);
         repeat (260) @(posedge clk_i);
         bus(0, UASC_STA_OFS, 32'h0100, 32'h0300);
         chk((s == 0) ? 5 : (s == 1) ? 2 : 1, nt - n0);
      end
      // break then one all-ones character: 13 + 1 low bits
      n0 = nl;
      bus(1, UASC_STA_OFS, 32'h0C00);
      bus(1, UASC_TXD_OFS, 32'hFF);
      repeat (120) @(posedge clk_i);
      chk(56, nl - n0);
      bus(0, UASC_STA_OFS, 32'h0100, 32'h0900);
      // abort in mid-frame
      bus(1, UASC_TXD_OFS, 32'h55);
      bus(1, UASC_TXD_OFS, 32'h55);
      repeat (10) @(posedge clk_i);
      bus(1, UASC_STA_OFS, 32'h0);
      bus(0, UASC_STA_OFS, 32'h0110, 32'hFFFF);
      // receive request modes 0x, 10, 11 over four characters
      for (s = 0; s < 3; s++) begin
         bus(1, UASC_STA_OFS, (s == 0) ? 32'h0 : (s == 1) ? 32'h80 : 32'hC0);
         n0 = nr;
         for (i = 0; i < 4; i++) begin
            b[i] = 10'($urandom & 32'hFF);
            peer.send(b[i], 8, 1'b1);
         end
         repeat (8) @(posedge clk_i);
         bus(0, UASC_STA_OFS, 32'h0011, 32'h0013);
         for (i = 0; i < 4; i++)
            bus(0, UASC_RXD_OFS, {22'h0, b[i]}, 32'h1FF);
         chk((s == 0) ? 4 : 1, nr - n0);
         bus(0, UASC_STA_OFS, 32'h0010, 32'h0011);
      end
      // overrun on the fifth character, then clear flushes
      for (i = 0; i < 5; i++)
         peer.send(10'h0A5, 8, 1'b1);
      repeat (8) @(posedge clk_i);
      bus(0, UASC_STA_OFS, 32'h0003, 32'h0003);
      bus(1, UASC_STA_OFS, 32'h0);
      bus(0, UASC_STA_OFS, 32'h0010, 32'h0013);
      // bad parity, then bad stop
      bus(1, UASC_MODE_OFS, 32'h2);
      k = $urandom & 32'hFF;
      peer.send({1'b0, ~^k[7:0], k[7:0]}, 9, 1'b1);
      peer.send({1'b0, ^k[7:0], k[7:0]}, 9, 1'b0);
      repeat (8) @(posedge clk_i);
      bus(0, UASC_STA_OFS, 32'h0008, 32'h000C);
      bus(0, UASC_RXD_OFS, k, 32'hFF);
      bus(0, UASC_STA_OFS, 32'h0004, 32'h000C);
      bus(0, UASC_RXD_OFS, k, 32'hFF);
      // address detect in 9-bit format drops data characters
      bus(1, UASC_MODE_OFS, 32'h6);
      bus(1, UASC_STA_OFS, 32'h20);
      peer.send(10'h05A, 9, 1'b1);
      peer.send(10'h1A5, 9, 1'b1);
      repeat (8) @(posedge clk_i);
      bus(0, UASC_RXD_OFS, 32'h1A5, 32'h1FF);
      bus(0, UASC_STA_OFS, 32'h0, 32'h1);
      bus(0, 8'h14, 32'h0, 32'hFFFFFFFF);
      print_verdict();
   end
endmodule
`default_nettype wire
